// ===== hdl/cpu_exception_sequencer.sv
/*
 Exception sequencer: ranks reset, interrupts and traps, stacks state and fetches vectors.
 Assumes a core that halts while core_run is low and a longword memory port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.svh"
module cpu_exception_sequencer
    import exc_seq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic init_input_pin_n,
    input wire logic nmi_req,
    input wire logic [`NUM_SRC-1:0] irq_lines,
    input wire logic insn_done,
    input wire logic trap_req,
    input wire logic [1:0] trap_num,
    input wire logic [23:0] pc_in,
    input wire logic [23:0] sp_in,
    input wire logic flags_we,
    input wire logic [7:0] flags_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic core_run,
    output core_load_t load,
    output logic [7:0] condition_flags,
    output logic int_ack,
    output logic [4:0] int_ack_src,
    output logic nmi_ack,
    output mem_req_t mem,
    output logic [1:0] wait_states,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [23:0] even_addr(input logic [23:0] a);
        even_addr = {a[23:1], 1'b0};
    endfunction : even_addr
    function automatic logic [5:0] src_vec(input logic [4:0] i);
        logic [5:0] k;
        k = {1'b0, i} - 6'h03;
        src_vec = (i == 5'h00) ? `VEC_IRQ0 : (i == 5'h01) ? `VEC_IRQ1 :
                  (i == 5'h02) ? `VEC_IRQ4 : `VEC_INT0 + {k[4:0], 1'b0};
    endfunction : src_vec
    function automatic logic src_level(input logic [4:0] i, input logic [7:0] a,
                                       input logic [7:0] b);
        logic [4:0] k;
        k = i - 5'h03;
        case (i)
            5'h00: src_level = a[7];
            5'h01: src_level = a[6];
            5'h02: src_level = a[4];
            default: begin
                case (k[4:2])
                    3'h0: src_level = a[2];
                    3'h1: src_level = a[1];
                    3'h2: src_level = a[0];
                    3'h3: src_level = b[7];
                    default: src_level = b[6];
                endcase
            end
        endcase
    endfunction : src_level

    // ----------------------------------------
    // Reset pin synchroniser
    // ----------------------------------------
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg, pin_rise;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= init_input_pin_n;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end
    // A glitch on the pin is ignored until two stages agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_level_reg <= 1'b0;
        end else if (pin_s2_reg == pin_s3_reg) begin
            pin_level_reg <= pin_s3_reg;
        end
    end
    assign pin_rise = !pin_level_reg && pin_s2_reg && pin_s3_reg;
    logic sys_rst;
    assign sys_rst = !aresetn || !pin_level_reg;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [7:0] system_control_reg, priority_level_reg_a, priority_level_reg_b;
    logic [1:0] wait_reg;
    logic wr_fire, wr_hit;
    logic [7:0] wr_addr_reg;
    logic [31:0] wr_data_reg;
    logic [3:0] wr_strb_reg;
    logic user_bit_select;
    assign user_bit_select = system_control_reg[`UBS_BIT];
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            system_control_reg <= `SYSCTL_RST;
            priority_level_reg_a <= `PRIO_RST;
            priority_level_reg_b <= `PRIO_RST;
            wait_reg <= `WAIT_RST;
        end else if (wr_fire && wr_strb_reg[0]) begin
            case (wr_addr_reg)
                `OFS_SYSCTL: system_control_reg <= wr_data_reg[7:0] | `SYSCTL_RO1;
                `OFS_PRIO_A: priority_level_reg_a <= wr_data_reg[7:0];
                `OFS_PRIO_B: priority_level_reg_b <= wr_data_reg[7:0];
                `OFS_WAIT: wait_reg <= wr_data_reg[1:0];
                default: ;
            endcase
        end
    end
    assign wait_states = wait_reg;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    seq_state_t state_reg;
    logic [7:0] condition_flags_reg;
    logic [5:0] vec_reg;
    logic first_insn_reg, nmi_pend_reg, trap_pend_reg, is_reset_reg;
    logic [1:0] trap_num_reg;
    logic [23:0] pc_reg, sp_reg;
    logic window, int_take, trap_take, take_nmi;
    logic [4:0] pick_src;
    logic pick_ok;
    logic [5:0] take_vec;
    // Arbitration: level 1 sources first, lowest index wins within a level.
    always_comb begin
        logic ok1, ok0, elig;
        logic [4:0] s1, s0;
        ok1 = 1'b0;
        ok0 = 1'b0;
        elig = 1'b0;
        s1 = 5'h00;
        s0 = 5'h00;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            elig = irq_lines[i] && (!condition_flags_reg[`FLAG_I] ||
                   (!user_bit_select && !condition_flags_reg[`FLAG_MASK2] &&
                    src_level(i[4:0], priority_level_reg_a, priority_level_reg_b)));
            if (elig && src_level(i[4:0], priority_level_reg_a, priority_level_reg_b)) begin
                ok1 = 1'b1;
                s1 = i[4:0];
            end else if (elig) begin
                ok0 = 1'b1;
                s0 = i[4:0];
            end
        end
        pick_ok = ok1 || ok0;
        pick_src = ok1 ? s1 : s0;
    end
    // Boundary: an instruction or a trap has finished, or an exception sequence is ending.
    assign window = !first_insn_reg && ((state_reg == ST_RUN && (insn_done || trap_pend_reg)) ||
                    state_reg == ST_LOAD);
    assign take_nmi = window && nmi_pend_reg;
    assign int_take = take_nmi || (window && pick_ok);
    assign trap_take = (state_reg == ST_RUN || state_reg == ST_LOAD) && trap_pend_reg &&
                       !int_take;
    assign take_vec = take_nmi ? `VEC_NMI :
                      int_take ? src_vec(pick_src) :
                      `VEC_TRAP0 + {4'h0, trap_num_reg};
    assign int_ack = int_take;
    assign nmi_ack = take_nmi;
    assign int_ack_src = pick_src;
    // Pending events: a new request in the cycle of its service is kept.
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            nmi_pend_reg <= 1'b0;
        end else if (nmi_req) begin
            nmi_pend_reg <= 1'b1;
        end else if (take_nmi) begin
            nmi_pend_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            trap_pend_reg <= 1'b0;
            trap_num_reg <= 2'h0;
        end else if (trap_req) begin
            trap_pend_reg <= 1'b1;
            trap_num_reg <= trap_num;
        end else if (trap_take) begin
            trap_pend_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            first_insn_reg <= 1'b1;
        end else if (state_reg == ST_RUN && insn_done) begin
            first_insn_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            state_reg <= (pin_rise && aresetn) ? ST_VEC : ST_RESET;
            vec_reg <= `VEC_RESET;
            is_reset_reg <= 1'b1;
            pc_reg <= 24'h00_0000;
            sp_reg <= 24'h00_0000;
        end else begin
            case (state_reg)
                ST_RUN, ST_LOAD: begin
                    state_reg <= ST_RUN;
                    if (int_take || trap_take) begin
                        state_reg <= ST_PUSH;
                        vec_reg <= take_vec;
                        is_reset_reg <= 1'b0;
                        sp_reg <= even_addr(sp_in - `STACK_LONG);
                    end
                end
                ST_PUSH: begin
                    if (mem_ack) begin
                        state_reg <= ST_VEC;
                    end
                end
                ST_VEC: begin
                    if (mem_ack) begin
                        state_reg <= ST_LOAD;
                        pc_reg <= mem_rdata[23:0];
                    end
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end
    // Mask bits are set only after the push, so the stacked flags are the old ones.
    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            condition_flags_reg <= `FLAGS_RST;
        end else if (state_reg == ST_PUSH && mem_ack) begin
            condition_flags_reg[`FLAG_I] <= 1'b1;
            if (!user_bit_select) begin
                condition_flags_reg[`FLAG_MASK2] <= 1'b1;
            end
        end else if (state_reg == ST_RUN && flags_we) begin
            condition_flags_reg <= flags_wdata;
        end
    end
    assign condition_flags = condition_flags_reg;
    assign core_run = state_reg == ST_RUN;

    always_comb begin
        mem.req = state_reg == ST_PUSH || state_reg == ST_VEC;
        mem.we = state_reg == ST_PUSH;
        mem.addr = (state_reg == ST_PUSH) ? even_addr(sp_reg) :
                   even_addr({16'h0000, vec_reg, 2'b00});
        mem.wdata = {condition_flags_reg, pc_in};
        load.valid = state_reg == ST_LOAD;
        load.sp_we = state_reg == ST_LOAD && !is_reset_reg;
        load.pc = pc_reg;
        load.sp = sp_reg;
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_full_reg, w_full_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 32'h0000_0000;
            wr_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                wr_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wr_data_reg <= s_axi_wdata;
                wr_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_hit = wr_addr_reg[7:2] <= `OFS_WAIT >> 2 && wr_addr_reg[1:0] == 2'b00;
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `OFS_SYSCTL: s_axi_rdata <= {24'h00_0000, system_control_reg};
                `OFS_PRIO_A: s_axi_rdata <= {24'h00_0000, priority_level_reg_a};
                `OFS_PRIO_B: s_axi_rdata <= {24'h00_0000, priority_level_reg_b};
                `OFS_WAIT: s_axi_rdata <= {30'h0000_0000, wait_reg};
                `OFS_STATUS: s_axi_rdata <= {12'h000, nmi_pend_reg, trap_pend_reg,
                    first_insn_reg, vec_reg, state_reg, condition_flags_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_holds_state: assert property (!pin_level_reg && !pin_rise |=> state_reg == ST_RESET)
        else $error("sequencer left reset while pin low");
    a_rise_fetch_vec: assert property (pin_rise |=> state_reg == ST_VEC && vec_reg == 6'h00 &&
        mem.addr == 24'h00_0000) else $error("reset vector not fetched");
    a_even_address: assert property (mem.req |-> !mem.addr[0])
        else $error("odd address on longword access");
    a_push_before_vec: assert property ($rose(state_reg == ST_VEC) |->
        $past(state_reg) == ST_PUSH || $past(state_reg) == ST_RESET)
        else $error("vector fetched without push");
    a_mask_after_push: assert property (state_reg == ST_PUSH && mem_ack |=>
        condition_flags_reg[7] && (user_bit_select || condition_flags_reg[6]))
        else $error("mask bits not set");
    a_first_insn_block: assert property (first_insn_reg |-> !int_ack)
        else $error("interrupt before first instruction");
    a_nmi_top_rank: assert property (nmi_ack |-> take_vec == 6'h07 && !trap_take)
        else $error("nmi not ranked first");
    a_trap_vector: assert property (trap_take |-> take_vec == 6'h08 + {4'h0, trap_num_reg})
        else $error("wrong trap vector");
    a_wait_default: assert property (!pin_level_reg |=> wait_states == 2'h3)
        else $error("wait states not three after reset");
    a_reset_mask_set: assert property ($rose(pin_level_reg) |-> condition_flags_reg[7])
        else $error("mask clear after reset");
    c_reset_exit: cover property (pin_rise ##[1:20] load.valid);
    c_trap_taken: cover property (trap_take ##[1:20] load.valid);
    c_nmi_taken: cover property (nmi_ack ##[1:20] load.valid);
endmodule : cpu_exception_sequencer
`default_nettype wire

// ===== hdl/exc_seq_defines.svh
/*
 Offsets, field positions, reset values and vector numbers of the exception sequencer.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef EXC_SEQ_DEFINES_SVH
`define EXC_SEQ_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SYSCTL 8'h00
`define OFS_PRIO_A 8'h04
`define OFS_PRIO_B 8'h08
`define OFS_WAIT 8'h0C
`define OFS_STATUS 8'h10
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define SYSCTL_RST 8'h0B
`define SYSCTL_RO1 8'h02
`define UBS_BIT 3
`define PRIO_RST 8'h00
`define WAIT_RST 2'h3
`define FLAG_I 7
`define FLAG_MASK2 6
`define FLAGS_RST 8'h80
// ----------------------------------------
// Vector numbers, source count and stack step
// ----------------------------------------
`define VEC_RESET 6'h00
`define VEC_NMI 6'h07
`define VEC_TRAP0 6'h08
`define VEC_IRQ0 6'h0C
`define VEC_IRQ1 6'h0D
`define VEC_IRQ4 6'h10
`define VEC_INT0 6'h14
`define NUM_SRC 23
`define STACK_LONG 24'h00_0004
`endif

// ===== hdl/exc_seq_pkg.sv
/*
 Types shared by the exception sequencer.
 Assumes the defines header is on the include path.
*/
`include "exc_seq_defines.svh"
package exc_seq_pkg;
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN = 3'b001,
        ST_PUSH = 3'b010,
        ST_VEC = 3'b011,
        ST_LOAD = 3'b100
    } seq_state_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
    typedef struct packed {
        logic valid;
        logic sp_we;
        logic [23:0] pc;
        logic [23:0] sp;
    } core_load_t;
endpackage : exc_seq_pkg

// ===== sim/exc_mem_model.sv
/*
 Longword memory seen by the exception sequencer: answers stack writes and vector reads.
 Assumes the sequencer holds mem.req until mem_ack, and that a vector word reads as 0x10_0000
 plus the byte address.
*/
`timescale 1ns/1ps
`default_nettype none
module exc_mem_model
    import exc_seq_pkg::*;
(
    input wire logic aclk,
    input wire logic slow,
    input wire mem_req_t mem,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [23:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [23:0] rd_addr,
    output int wr_cnt
);
    int wait_cnt = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        wr_cnt = 0;
    end
    // Read data is only good in the acknowledge cycle; it flips otherwise so a late sample shows.
    always @(posedge aclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem.req && !mem_ack) begin
            if (wait_cnt < (slow ? 3 : 0)) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                mem_ack <= 1'b1;
                if (mem.we) begin
                    wr_addr <= mem.addr;
                    wr_data <= mem.wdata;
                    wr_cnt <= wr_cnt + 1;
                end else begin
                    rd_addr <= mem.addr;
                    mem_rdata <= {16'h0010, mem.addr[15:0]};
                end
            end
        end
    end
endmodule : exc_mem_model
`default_nettype wire

// ===== sim/tb_top.sv
/*
 Self-checking testbench of the exception sequencer: reset, traps, interrupts and priority.
 Assumes the package, the sequencer and the memory model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exc_seq_defines.svh"
module tb_top
    import exc_seq_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, init_input_pin_n = 1'b1, slow = 1'b0;
    logic nmi_req = 1'b0, insn_done = 1'b0, trap_req = 1'b0, flags_we = 1'b0;
    logic [1:0] trap_num = 2'h0;
    logic [7:0] flags_wdata = 8'h00;
    logic [`NUM_SRC-1:0] irq_lines = '0;
    logic mem_ack, core_run, int_ack, nmi_ack;
    logic [31:0] mem_rdata, wr_data, rdat;
    logic [23:0] wr_addr, rd_addr;
    logic [4:0] int_ack_src, ack_src;
    logic [7:0] condition_flags;
    logic [1:0] wait_states, resp;
    core_load_t load;
    mem_req_t mem;
    int wr_cnt, ack_cnt = 0, nmi_cnt = 0, num_errors = 0, checks_done = 0, cycles = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;

    always #4 aclk = ~aclk;

    cpu_exception_sequencer cpu_exception_sequencer_inst (
        .aclk, .aresetn, .init_input_pin_n, .nmi_req, .irq_lines, .insn_done, .trap_req,
        .trap_num, .pc_in(24'h00_1234), .sp_in(24'h00_2001), .flags_we, .flags_wdata,
        .mem_ack, .mem_rdata, .core_run, .load, .condition_flags, .int_ack, .int_ack_src,
        .nmi_ack, .mem, .wait_states, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    exc_mem_model exc_mem_model_inst (.aclk, .slow, .mem, .mem_ack, .mem_rdata, .wr_addr,
        .wr_data, .rd_addr, .wr_cnt);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("Checks: %0d, errors: %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (int_ack === 1'b1) begin
            ack_cnt <= ack_cnt + 1;
            ack_src <= int_ack_src;
        end
        if (nmi_ack === 1'b1) begin
            nmi_cnt <= nmi_cnt + 1;
        end
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Every bus task starts on a fresh edge, so a strobe lowered by the last call never meets
    // its own raise in one time step.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axi_rd

    task automatic pulse_core(input logic nmi, input logic ins, input logic trp,
                              input logic [1:0] num);
        @(posedge aclk);
        nmi_req <= nmi;
        insn_done <= ins;
        trap_req <= trp;
        trap_num <= num;
        @(posedge aclk);
        nmi_req <= 1'b0;
        insn_done <= 1'b0;
        trap_req <= 1'b0;
    endtask : pulse_core

    task automatic set_flags(input logic [7:0] d);
        @(posedge aclk);
        flags_we <= 1'b1;
        flags_wdata <= d;
        @(posedge aclk);
        flags_we <= 1'b0;
    endtask : set_flags

    // Waits for the handler load and judges stacking, vector fetch and flags of one exception.
    task automatic serve(input int v, input logic push, input logic [7:0] fb,
                         input logic [7:0] fa);
        int n;
        int w0;
        n = 0;
        w0 = wr_cnt;
        do begin
            @(posedge aclk);
            n = n + 1;
        end while (load.valid !== 1'b1 && n < 300);
        chk(32'(load.pc), 32'h0010_0000 + 32'(v * 4));
        chk(32'(rd_addr), 32'(v * 4));
        chk(32'(load.sp_we), 32'(push));
        chk(32'(wr_cnt - w0), 32'(push));
        if (push) begin
            chk(32'(wr_addr), 32'h0000_1FFC);
            chk(32'(load.sp), 32'h0000_1FFC);
            chk(wr_data, {fb, 24'h00_1234});
        end
        chk(32'(condition_flags), 32'(fa));
    endtask : serve

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        axi_rd(8'h00);
        chk(rdat, 32'h0000_000B);
        chk(32'(wait_states), 32'h0000_0003);
        axi_rd(8'h14);
        chk(32'(resp), 32'h0000_0002);
        axi_wr(8'h10, 32'h0000_00FF);
        chk(32'(resp), 32'h0000_0002);
    endtask : t_regs

    task automatic t_pin_reset();
        axi_wr(8'h0C, 32'h0000_0000);
        axi_wr(8'h00, 32'h0000_0003);
        @(posedge aclk);
        init_input_pin_n <= 1'b0;
        repeat (12) @(posedge aclk);
        chk(32'(core_run), 32'h0000_0000);
        chk(32'(mem.req), 32'h0000_0000);
        init_input_pin_n <= 1'b1;
        serve(0, 1'b0, 8'h00, 8'h80);
        chk(32'(wait_states), 32'h0000_0003);
        axi_rd(8'h00);
        chk(rdat, 32'h0000_000B);
    endtask : t_pin_reset

    task automatic t_blocked();
        pulse_core(1'b1, 1'b0, 1'b0, 2'h0);
        repeat (20) @(posedge aclk);
        chk(32'(ack_cnt + nmi_cnt), 32'h0000_0000);
        pulse_core(1'b0, 1'b1, 1'b0, 2'h0);
        chk(32'(nmi_cnt), 32'h0000_0000);
        pulse_core(1'b0, 1'b1, 1'b0, 2'h0);
        serve(7, 1'b1, 8'h80, 8'h80);
        chk(32'(nmi_cnt), 32'h0000_0001);
    endtask : t_blocked

    task automatic t_traps();
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            pulse_core(1'b0, 1'b0, 1'b1, k[1:0]);
            serve(8 + k, 1'b1, 8'h80, 8'h80);
        end
        axi_wr(8'h00, 32'h0000_0003);
        pulse_core(1'b0, 1'b0, 1'b1, 2'h3);
        serve(11, 1'b1, 8'h80, 8'hC0);
        axi_wr(8'h00, 32'h0000_000B);
    endtask : t_traps

    task automatic t_prio();
        logic [22:0] lines [4] = '{23'h00_0003, 23'h00_0005, 23'h00_0006, 23'h00_0008};
        logic [7:0] prio [4] = '{8'h00, 8'h10, 8'h40, 8'h00};
        int vec [4] = '{12, 16, 13, 20};
        int src [4] = '{0, 2, 1, 3};
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'h04, {24'h00_0000, prio[i]});
            set_flags(8'h00);
            irq_lines <= lines[i];
            pulse_core(1'b0, 1'b1, 1'b0, 2'h0);
            serve(vec[i], 1'b1, 8'h00, 8'h80);
            chk(32'(ack_src), 32'(src[i]));
            irq_lines <= '0;
        end
    endtask : t_prio

    // NMI and a trap raised together: the interrupt goes first, the trap waits its turn.
    task automatic t_simul();
        pulse_core(1'b1, 1'b1, 1'b1, 2'h2);
        serve(7, 1'b1, 8'h80, 8'h80);
        serve(10, 1'b1, 8'h80, 8'h80);
    endtask : t_simul

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pin_reset();
        t_blocked();
        t_traps();
        t_prio();
        t_simul();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
